// file: rtl/lrs_params.svh
// timing counts, widths and reset values for the reject and sequence-reset block
`ifndef LRS_PARAMS_SVH
`define LRS_PARAMS_SVH
`define LRS_CLK_PERIOD_NS   10
`define LRS_ACK_TIME_US     1000
`define LRS_ACK_CYCLES      ((`LRS_ACK_TIME_US * 1000) / `LRS_CLK_PERIOD_NS)
`define LRS_N2_DEFAULT      8'h03
`define LRS_SEQ_W           7
`define LRS_SEQ_RESET       7'h00
`define LRS_INFO_W          40
`endif

// file: rtl/lrs_pkg.sv
// types for the reject and sequence-reset block
package lrs_pkg;
   typedef enum logic [3:0] {
      LRS_PDU_NONE  = 4'h0,
      LRS_PDU_I     = 4'h1,
      LRS_PDU_S     = 4'h2,
      LRS_PDU_SABME = 4'h3,
      LRS_PDU_DISC  = 4'h4,
      LRS_PDU_RSET  = 4'h5,
      LRS_PDU_UA    = 4'h6,
      LRS_PDU_DM    = 4'h7,
      LRS_PDU_FRMR  = 4'h8,
      LRS_PDU_OTHER = 4'h9
   } lrs_pdu_e;

   typedef enum logic [1:0] {
      LRS_ST_NORMAL = 2'b00,
      LRS_ST_FRMR   = 2'b01,
      LRS_ST_RSET   = 2'b11
   } lrs_state_e;

   // one received or transmitted pdu event
   typedef struct packed {
      logic      valid;
      lrs_pdu_e  kind;
      logic      is_cmd;
      logic      bad_nr;
      logic      reject;
   } lrs_pdu_s;

   typedef struct packed {
      logic enter_frmr;
      logic leave_frmr;
      logic n2_reset;
   } lrs_event_s;
endpackage

// file: rtl/lrs_ack_timer.sv
// acknowledgement timer: load, stop, expiry pulse
`timescale 1ns/10ps
module lrs_ack_timer #(
   parameter int unsigned CYCLES = 100000
) (
   input  wire logic clk_in,
   input  wire logic arst_n_in,
   input  wire logic start_in,
   input  wire logic stop_in,
   output logic      running_out,
   output logic      expire_out
);
   logic [31:0] cnt_q;
   logic        run_q;
   logic        exp_q;
   wire         at_end = run_q && (cnt_q == 32'h0000_0001);

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt_q <= 32'h0000_0000;
         run_q <= 1'b0;
         exp_q <= 1'b0;
      end else begin
         exp_q <= at_end && !start_in && !stop_in;
         if (stop_in) begin
            run_q <= 1'b0;
         end else if (start_in) begin
            cnt_q <= CYCLES;
            run_q <= 1'b1;
         end else if (run_q) begin
            cnt_q <= cnt_q - 32'h0000_0001;
            run_q <= !at_end;
         end
      end
   end

   assign running_out = run_q;
   assign expire_out  = exp_q;
endmodule

// file: rtl/lrs_core.sv
// frame-reject exception and sequence-number reset control
//
// Overview of operation
// - on timer expiry in the reject exception the FRMR is resent and the timer restarted.
// - after N2 expiries in the reject exception a SABME command is sent instead.
// - an extra FRMR sent while the timer runs leaves the timer alone.
// - an accepted RSET is answered with UA at the first transmit chance.
// - accepting RSET clears the receive state variable to zero.
// - the RSET issuer clears its send state variable only on the matching UA.
// - accepting RSET clears all rejection conditions except a reported bad N(R).
// - a bad N(R) condition is cleared only by an RSET sent by the detecting station or by a received SABME.
// - a rejected PDU during information transfer causes an FRMR response.
// - in the normal state a received FRMR makes the station start a reset with RSET.
// - after sending FRMR the station holds the reject exception until cleared.
// - in the reject exception no I PDU is sent and received I and S PDUs are dropped.
// - sending SABME, DISC or RSET, or receiving SABME, DISC, RSET or DM, clears the reject exception.
// - any other command in the reject exception resends FRMR with the same info field.
`timescale 1ns/10ps
`include "lrs_params.svh"
module lrs_core #(
   parameter int unsigned ACK_CYCLES = `LRS_ACK_CYCLES,
   parameter int unsigned SEQ_W      = `LRS_SEQ_W,
   parameter int unsigned INFO_W     = `LRS_INFO_W
) (
   input  wire logic                 clk_in,
   input  wire logic                 arst_n_in,
   input  wire lrs_pkg::lrs_pdu_s    rx_pdu_in,
   input  wire logic [INFO_W-1:0]    rx_info_in,
   input  wire logic                 info_xfer_in,
   input  wire logic [7:0]           n2_in,
   input  wire logic                 host_rset_in,
   input  wire logic                 tx_ready_in,
   input  wire logic                 vr_inc_in,
   input  wire logic                 vs_inc_in,
   output lrs_pkg::lrs_pdu_e         tx_kind_out,
   output logic                      tx_valid_out,
   output logic [INFO_W-1:0]         tx_info_out,
   output logic                      i_tx_allow_out,
   output logic                      rx_deliver_out,
   output logic [SEQ_W-1:0]          vr_out,
   output logic [SEQ_W-1:0]          vs_out,
   output logic                      bad_nr_hold_out,
   output logic                      reject_hold_out,
   output lrs_pkg::lrs_event_s       event_out,
   output lrs_pkg::lrs_state_e       state_out
);
   import lrs_pkg::*;

   // ***************************************
   // receive decode
   // ***************************************
   lrs_state_e        st_q, st_d;
   logic [7:0]        exp_cnt_q;
   logic [SEQ_W-1:0]  vr_q, vs_q;
   logic [INFO_W-1:0] info_q;
   logic              bad_nr_q, rej_q, rset_own_q;
   lrs_pdu_e          pend_q;
   logic              tmr_run, tmr_exp;

   function automatic logic is_kind(input lrs_pdu_s p, input lrs_pdu_e k);
      return p.valid && (p.kind == k);
   endfunction

   wire in_frmr  = (st_q == LRS_ST_FRMR);
   wire rx_sabme = is_kind(rx_pdu_in, LRS_PDU_SABME);
   wire rx_disc  = is_kind(rx_pdu_in, LRS_PDU_DISC);
   wire rx_rset  = is_kind(rx_pdu_in, LRS_PDU_RSET);
   wire rx_dm    = is_kind(rx_pdu_in, LRS_PDU_DM);
   wire rx_ua    = is_kind(rx_pdu_in, LRS_PDU_UA);
   wire rx_frmr  = is_kind(rx_pdu_in, LRS_PDU_FRMR);
   wire rx_is    = is_kind(rx_pdu_in, LRS_PDU_I) || is_kind(rx_pdu_in, LRS_PDU_S);
   wire rx_rej   = rx_pdu_in.valid && rx_pdu_in.reject && info_xfer_in && !in_frmr;
   wire tx_fire  = tx_valid_out && tx_ready_in;
   wire tx_clear = tx_fire && ((pend_q == LRS_PDU_SABME) || (pend_q == LRS_PDU_DISC)
                               || (pend_q == LRS_PDU_RSET));
   wire clear_exc = rx_sabme || rx_disc || rx_rset || rx_dm || tx_clear;
   wire other_cmd = in_frmr && rx_pdu_in.valid && rx_pdu_in.is_cmd && !clear_exc;
   wire n2_hit    = in_frmr && tmr_exp && ((exp_cnt_q + 8'h01) >= n2_in);
   wire retry     = in_frmr && tmr_exp && !n2_hit;

   // ***************************************
   // state and transmit request
   // ***************************************
   always_comb begin
      st_d = st_q;
      case (st_q)
         LRS_ST_NORMAL: begin
            if (rx_rej)
               st_d = LRS_ST_FRMR;
            else if (host_rset_in || rx_frmr)
               st_d = LRS_ST_RSET;
         end
         LRS_ST_FRMR: begin
            if (clear_exc && !rx_rset)
               st_d = LRS_ST_NORMAL;
            else if (rx_rset)
               st_d = LRS_ST_NORMAL;
         end
         LRS_ST_RSET: begin
            if (rx_ua || rx_dm)
               st_d = LRS_ST_NORMAL;
         end
         default: st_d = LRS_ST_NORMAL;
      endcase
   end

   // transmit slot priority: UA answer, forced SABME, FRMR, RSET request
   logic     set_pend;
   lrs_pdu_e new_pend;
   always_comb begin
      set_pend = 1'b1;
      new_pend = LRS_PDU_NONE;
      if (rx_rset || rx_sabme)
         new_pend = LRS_PDU_UA;
      else if (n2_hit)
         new_pend = LRS_PDU_SABME;
      else if (rx_rej || retry || other_cmd)
         new_pend = LRS_PDU_FRMR;
      else if (st_q == LRS_ST_NORMAL && (host_rset_in || rx_frmr))
         new_pend = LRS_PDU_RSET;
      else
         set_pend = 1'b0;
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_q   <= LRS_ST_NORMAL;
         pend_q <= LRS_PDU_NONE;
      end else begin
         st_q <= st_d;
         if (set_pend)
            pend_q <= new_pend;
         else if (tx_fire)
            pend_q <= LRS_PDU_NONE;
      end
   end

   // ***************************************
   // timer and expiry count
   // ***************************************
   wire frmr_sent = tx_fire && (pend_q == LRS_PDU_FRMR);
   // an extra FRMR while running must not reload
   wire tmr_start = (frmr_sent && !tmr_run) || (retry && frmr_sent);
   wire tmr_stop  = clear_exc || !in_frmr;

   lrs_ack_timer #(.CYCLES(ACK_CYCLES)) lrs_ack_timer_i (
      .clk_in      (clk_in),
      .arst_n_in   (arst_n_in),
      .start_in    (tmr_start && in_frmr),
      .stop_in     (tmr_stop),
      .running_out (tmr_run),
      .expire_out  (tmr_exp)
   );

   wire enter_ev = (st_q != LRS_ST_FRMR) && (st_d == LRS_ST_FRMR);
   wire leave_ev = in_frmr && (st_d != LRS_ST_FRMR);

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in)
         exp_cnt_q <= 8'h00;
      else if (enter_ev || leave_ev)
         exp_cnt_q <= 8'h00;
      else if (in_frmr && tmr_exp)
         exp_cnt_q <= exp_cnt_q + 8'h01;
   end

   // ***************************************
   // sequence variables and rejection conditions
   // ***************************************
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         vr_q       <= `LRS_SEQ_RESET;
         vs_q       <= `LRS_SEQ_RESET;
         bad_nr_q   <= 1'b0;
         rej_q      <= 1'b0;
         rset_own_q <= 1'b0;
         info_q     <= '0;
      end else begin
         if (rx_rset)
            vr_q <= `LRS_SEQ_RESET;
         else if (vr_inc_in && !in_frmr)
            vr_q <= vr_q + SEQ_W'(1);
         if (st_q == LRS_ST_RSET && rx_ua && rset_own_q)
            vs_q <= `LRS_SEQ_RESET;
         else if (vs_inc_in && !in_frmr)
            vs_q <= vs_q + SEQ_W'(1);
         if (tx_fire && pend_q == LRS_PDU_RSET)
            rset_own_q <= 1'b1;
         else if (st_q != LRS_ST_RSET)
            rset_own_q <= 1'b0;
         if (rx_rej) begin
            info_q <= rx_info_in;
            rej_q  <= 1'b1;
         end else if (rx_rset || rx_sabme) begin
            rej_q <= 1'b0;
         end
         // bad N(R) sets win; only our own RSET or a received SABME clears it
         if (rx_rej && rx_pdu_in.bad_nr)
            bad_nr_q <= 1'b1;
         else if ((tx_fire && pend_q == LRS_PDU_RSET) || rx_sabme)
            bad_nr_q <= 1'b0;
      end
   end

   // ***************************************
   // outputs
   // ***************************************
   assign tx_valid_out    = (pend_q != LRS_PDU_NONE);
   assign tx_kind_out     = pend_q;
   assign tx_info_out     = info_q;
   assign i_tx_allow_out  = !in_frmr;
   assign rx_deliver_out  = rx_is && !in_frmr;
   assign vr_out          = vr_q;
   assign vs_out          = vs_q;
   assign bad_nr_hold_out = bad_nr_q;
   assign reject_hold_out = rej_q;
   assign state_out       = st_q;
   assign event_out       = '{enter_frmr: enter_ev, leave_frmr: leave_ev,
                              n2_reset: n2_hit};

   // ***************************************
   // assertions
   // ***************************************
   AST_N2_SABME: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      n2_hit && !(rx_rset || rx_sabme) |=> pend_q == LRS_PDU_SABME)
      else $error("n2 limit did not queue sabme");
   AST_RETRY_FRMR: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      retry && !(rx_rset || rx_sabme) |=> pend_q == LRS_PDU_FRMR)
      else $error("timer expiry did not queue frmr");
   AST_NO_RELOAD: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      frmr_sent && tmr_run && !tmr_stop && (lrs_ack_timer_i.cnt_q > 32'h0000_0001)
      |=> lrs_ack_timer_i.cnt_q == $past(lrs_ack_timer_i.cnt_q) - 32'h0000_0001)
      else $error("timer reloaded by extra frmr");
   AST_UA_ON_RSET: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      rx_rset |=> pend_q == LRS_PDU_UA)
      else $error("rset not answered with ua");
   AST_VR_ZERO: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      rx_rset |=> vr_q == '0)
      else $error("vr not cleared by rset");
   AST_VS_HOLD: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      !rx_ua && !vs_inc_in |=> $stable(vs_q))
      else $error("vs changed without ua");
   AST_BADNR_KEEP: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      bad_nr_q && rx_rset && !rx_sabme && !(tx_fire && pend_q == LRS_PDU_RSET) |=> bad_nr_q)
      else $error("peer rset cleared bad nr");
   AST_ENTER_FRMR: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      rx_rej |=> in_frmr && pend_q == LRS_PDU_FRMR)
      else $error("reject did not enter frmr");
   AST_DISCARD: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      in_frmr |-> !rx_deliver_out && !i_tx_allow_out)
      else $error("traffic passed during frmr");
   AST_CLEAR: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      in_frmr && (rx_disc || rx_dm) |=> !in_frmr)
      else $error("frmr not cleared");
   AST_CNT_CLR: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      enter_ev |=> exp_cnt_q == 8'h00)
      else $error("expiry count not cleared");

   COV_FRMR: cover property (@(posedge clk_in) disable iff (!arst_n_in) rx_rej);
   COV_N2: cover property (@(posedge clk_in) disable iff (!arst_n_in) n2_hit);
   COV_RSET: cover property (@(posedge clk_in) disable iff (!arst_n_in) rx_rset ##1 tx_fire);
   COV_VS: cover property (@(posedge clk_in) disable iff (!arst_n_in) st_q == LRS_ST_RSET && rx_ua);
endmodule

// file: dv/lrs_peer_model.sv
// peer station model: takes transmitted pdus and answers reset requests
`timescale 1ns/10ps
module lrs_peer_model (
   input  wire logic             clk_in,
   input  wire logic             arst_n_in,
   input  wire logic             tx_valid_in,
   input  wire lrs_pkg::lrs_pdu_e tx_kind_in,
   input  wire logic             slow_in,
   input  wire logic             reply_en_in,
   input  wire lrs_pkg::lrs_pdu_e reply_kind_in,
   output logic                  tx_ready_out,
   output lrs_pkg::lrs_pdu_s     rx_pdu_out
);
   import lrs_pkg::*;
   logic [1:0] wait_q;
   logic       took_q;
   lrs_pdu_e   took_kind_q;

   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         took_q      <= 1'b0;
         took_kind_q <= LRS_PDU_NONE;
      end else begin
         took_q      <= tx_valid_in && tx_ready_out;
         took_kind_q <= tx_kind_in;
      end
   end

   // signals move on the falling edge, half a cycle clear of the sampling edge
   always @(negedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tx_ready_out <= 1'b0;
         wait_q       <= 2'h0;
         rx_pdu_out   <= '0;
      end else begin
         rx_pdu_out <= '0;
         if (took_q) begin
            tx_ready_out <= 1'b0;
            wait_q       <= 2'h0;
            if (reply_en_in && took_kind_q == LRS_PDU_RSET)
               rx_pdu_out <= '{1'b1, LRS_PDU_UA, 1'b0, 1'b0, 1'b0};
            if (reply_en_in && took_kind_q == LRS_PDU_FRMR)
               rx_pdu_out <= '{1'b1, reply_kind_in, 1'b1, 1'b0, 1'b0};
         end else if (tx_valid_in && !tx_ready_out) begin
            if (!slow_in || wait_q == 2'h3)
               tx_ready_out <= 1'b1;
            else
               wait_q <= wait_q + 2'h1;
         end
      end
   end
endmodule

// file: dv/link_reject_and_seq_reset_bench.sv
// self-checking bench for the reject and sequence-reset block
`timescale 1ns/10ps
module link_reject_and_seq_reset_bench;
   import lrs_pkg::*;
   localparam int ACK = 20;
   logic clk_in = 1'b0, arst_n_in = 1'b0, info_xfer = 1'b1, host_rset = 1'b0;
   logic vr_inc = 1'b0, vs_inc = 1'b0, slow = 1'b0, reply_en = 1'b0, tx_ready, tx_valid;
   logic [7:0] n2 = 8'h03;
   logic [39:0] rx_info = 40'h0, tx_info;
   logic [6:0] vr, vs;
   logic allow, deliver, bad_hold, rej_hold, saw_enter, saw_leave, saw_n2;
   lrs_pdu_e reply_kind = LRS_PDU_SABME, tx_kind;
   lrs_pdu_s tb_pdu = '0, peer_pdu, rx_mux;
   lrs_event_s ev;
   lrs_state_e state;
   int fail_count = 0, n_compared = 0, cyc = 0, n, t0;

   assign rx_mux = peer_pdu.valid ? peer_pdu : tb_pdu;
   always #5 clk_in = ~clk_in;

   lrs_core #(.ACK_CYCLES(ACK)) lrs_core_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .rx_pdu_in(rx_mux),
      .rx_info_in(rx_info), .info_xfer_in(info_xfer), .n2_in(n2), .host_rset_in(host_rset),
      .tx_ready_in(tx_ready), .vr_inc_in(vr_inc), .vs_inc_in(vs_inc), .tx_kind_out(tx_kind),
      .tx_valid_out(tx_valid), .tx_info_out(tx_info), .i_tx_allow_out(allow), .rx_deliver_out(deliver),
      .vr_out(vr), .vs_out(vs), .bad_nr_hold_out(bad_hold), .reject_hold_out(rej_hold),
      .event_out(ev), .state_out(state));
   lrs_peer_model lrs_peer_model_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .tx_valid_in(tx_valid),
      .tx_kind_in(tx_kind), .slow_in(slow), .reply_en_in(reply_en), .reply_kind_in(reply_kind),
      .tx_ready_out(tx_ready), .rx_pdu_out(peer_pdu));

   // sticky event flags, cleared by each test before use
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (ev.enter_frmr) saw_enter <= 1'b1;
      if (ev.leave_frmr) saw_leave <= 1'b1;
      if (ev.n2_reset) saw_n2 <= 1'b1;
      if (cyc == 3000) begin
         fail_count = fail_count + 1;
         print_verdict();
      end
   end

   // ******************************
   // shared tasks
   // ******************************
   task automatic check(input logic [39:0] got, input logic [39:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic send(input lrs_pdu_e k, input logic cmd, input logic bnr, input logic rej);
      @(negedge clk_in);
      tb_pdu = '{1'b1, k, cmd, bnr, rej};
      @(negedge clk_in);
      tb_pdu = '0;
   endtask

   task automatic pulse(ref logic s);
      @(negedge clk_in);
      s = 1'b1;
      @(negedge clk_in);
      s = 1'b0;
   endtask

   // one received pdu for a cycle; the delivery strobe is looked at while it stands
   task automatic probe_deliver(input lrs_pdu_e k, input logic exp);
      @(negedge clk_in);
      tb_pdu = '{1'b1, k, 1'b0, 1'b0, 1'b0};
      #1 check(deliver, exp);
      @(negedge clk_in);
      tb_pdu = '0;
   endtask

   // bounded wait until the peer has taken a pdu of the given kind
   task automatic wait_sent(input lrs_pdu_e k);
      n = 0;
      while (!(lrs_peer_model_i.took_q && lrs_peer_model_i.took_kind_q === k) && n < 300) begin
         @(negedge clk_in);
         n++;
      end
      check(n < 300, 1'b1);
      @(negedge clk_in);
   endtask

   task automatic enter_frmr(input logic bnr, input logic [39:0] info);
      saw_enter = 1'b0;
      rx_info = info;
      send(LRS_PDU_I, 1'b1, bnr, 1'b1);
      wait_sent(LRS_PDU_FRMR);
      check(state, LRS_ST_FRMR);
      check(tx_info, info);
      check(allow, 1'b0);
      check(saw_enter, 1'b1);
   endtask

   // ******************************
   // scenarios
   // ******************************
   task automatic t_timer_escalation();
      saw_n2 = 1'b0;
      probe_deliver(LRS_PDU_I, 1'b1);
      check(allow, 1'b1);
      enter_frmr(1'b0, 40'h5a3c_0f96_e1);
      t0 = cyc;
      probe_deliver(LRS_PDU_S, 1'b0);
      probe_deliver(LRS_PDU_I, 1'b0);
      repeat (6) @(negedge clk_in);
      send(LRS_PDU_OTHER, 1'b1, 1'b0, 1'b0);
      wait_sent(LRS_PDU_FRMR);
      check(tx_info, 40'h5a3c_0f96_e1);
      // a restart by the extra resend would push the limit out by fourteen cycles
      wait_sent(LRS_PDU_SABME);
      check(cyc - t0 >= 3 * ACK && cyc - t0 <= 3 * ACK + 12, 1'b1);
      check(saw_n2, 1'b1);
      check(state, LRS_ST_NORMAL);
      $display("test timer_escalation done");
   endtask

   task automatic t_peer_sabme();
      slow = 1'b1;
      saw_leave = 1'b0;
      enter_frmr(1'b0, 40'h0123_4567_89);
      // the peer answers the next timed resend, so the entry checks see the exception
      reply_en = 1'b1;
      wait_sent(LRS_PDU_UA);
      check(state, LRS_ST_NORMAL);
      check(saw_leave, 1'b1);
      slow = 1'b0;
      reply_en = 1'b0;
      $display("test peer_sabme done");
   endtask

   task automatic t_disc_dm_clear();
      enter_frmr(1'b0, 40'h3c5a_9669_a5);
      send(LRS_PDU_DISC, 1'b1, 1'b0, 1'b0);
      check(state, LRS_ST_NORMAL);
      enter_frmr(1'b0, 40'h3c5a_9669_a5);
      send(LRS_PDU_DM, 1'b0, 1'b0, 1'b0);
      check(state, LRS_ST_NORMAL);
      check(allow, 1'b1);
      $display("test disc_dm_clear done");
   endtask

   task automatic t_rset_accept();
      repeat (3) pulse(vr_inc);
      check(vr, 7'h03);
      enter_frmr(1'b1, 40'hfedc_ba98_76);
      send(LRS_PDU_RSET, 1'b1, 1'b0, 1'b0);
      wait_sent(LRS_PDU_UA);
      check(vr, 7'h00);
      check(rej_hold, 1'b0);
      check(bad_hold, 1'b1);
      check(state, LRS_ST_NORMAL);
      $display("test rset_accept done");
   endtask

   task automatic t_rset_issue();
      repeat (2) pulse(vs_inc);
      pulse(host_rset);
      wait_sent(LRS_PDU_RSET);
      repeat (3) @(negedge clk_in);
      check(vs, 7'h02);
      check(state, LRS_ST_RSET);
      send(LRS_PDU_UA, 1'b0, 1'b0, 1'b0);
      check(vs, 7'h00);
      check(state, LRS_ST_NORMAL);
      check(bad_hold, 1'b0);
      $display("test rset_issue done");
   endtask

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (3) @(negedge clk_in);
      arst_n_in = 1'b1;
      @(negedge clk_in);
      t_timer_escalation();
      t_peer_sabme();
      t_disc_dm_clear();
      t_rset_accept();
      t_rset_issue();
      print_verdict();
   end
endmodule
